// ---- logic/pdm_mic.sv ----
// pdm microphone end: modulator, half-slot driver, clock-rate modes
//
// Operation
// (RQ1) left mic drives half after falling edge
// (RQ2) right mic drives half after rising edge
// (RQ3) release data line in other half
// (RQ4) two mics share line, interleaved
// (RQ5) channel strap latched once after reset
// (RQ6) strap low right, strap high left
// (RQ7) amplitude coded as pulse density
// (RQ8) zero input gives alternating ones and zeros
// (RQ9) small three percent dc offset added
// (RQ10) output level limited at full scale
// (RQ11) low-power listening at 768 kHz clock
// (RQ12) below 200 kHz sleep, line released
// (RQ13) valid data 6 ms after clock returns
// (RQ14) start-up valid 6 ms after clock
// (RQ15) host makes clock, decodes both channels
// (RQ16) host decimation at least 20 bits
// (RQ17) mono host samples own edge only
`default_nettype none

module pdm_mic #(
    parameter int SAMPLE_W   = pdm_pkg::SAMPLE_W,
    parameter int WAKE_CYC   = pdm_pkg::WAKE_CYC,
    parameter int OFFSET_PCT = pdm_pkg::OFFSET_PCT
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    pdm_if.mic                              link,
    input  wire logic                       chan_sel_pin,
    input  wire logic signed [SAMPLE_W-1:0] sample,
    output logic                            chan_left,
    output logic                            low_power_listen_mode,
    output logic                            asleep,
    output logic                            settled
);

    // =====================================================================
    // derived sizes and levels
    // =====================================================================
    localparam int ACC_W  = SAMPLE_W + 3;
    localparam int FS     = 2 ** (SAMPLE_W - 1) - 1;
    localparam int OFFSET = FS * OFFSET_PCT / 100;
    localparam int WK_W   = $clog2(WAKE_CYC + 1);
    localparam int PER_W  = $clog2(pdm_pkg::SLEEP_CYC + 2);

    localparam logic signed [ACC_W-1:0] FS_POS = ACC_W'(FS);
    localparam logic signed [ACC_W-1:0] FS_NEG = ACC_W'(-FS);
    localparam logic signed [ACC_W-1:0] DC_OFS = ACC_W'(OFFSET);
    localparam logic [PER_W-1:0] SLEEP_LIM = PER_W'(pdm_pkg::SLEEP_CYC);
    localparam logic [PER_W-1:0] LISTEN_LO =
        PER_W'(pdm_pkg::LISTEN_CYC - pdm_pkg::LISTEN_TOL_CYC);
    localparam logic [PER_W-1:0] LISTEN_HI =
        PER_W'(pdm_pkg::LISTEN_CYC + pdm_pkg::LISTEN_TOL_CYC);
    localparam logic [WK_W-1:0]  WAKE_LAST = WK_W'(WAKE_CYC - 1);

    // =====================================================================
    // link-domain signals
    // =====================================================================
    logic                    sel_s1;
    logic                    sel_s2;
    logic [1:0]              sel_arm;
    logic                    sel_done;
    logic                    run_s1;
    logic                    run_s2;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] biased;
    logic signed [ACC_W-1:0] clipped;
    logic                    mod_bit;
    logic                    left_bit;
    logic                    rise_tog;
    logic                    fall_tog;
    logic                    high_half;

    // =====================================================================
    // reference-domain signals
    // =====================================================================
    logic                tog_s1;
    logic                tog_s2;
    logic                tog_s3;
    logic                clk_edge;
    logic [PER_W-1:0]    per_cnt;
    logic                timeout;
    logic [WK_W-1:0]     wake_cnt;
    pdm_pkg::pdm_state_t state;
    pdm_pkg::pdm_state_t next_state;

    // =====================================================================
    // channel strap capture (link clock)
    // =====================================================================

    // strap passes two flops, then is frozen once
    always_ff @(posedge link.pdm_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1    <= 1'b0;
            sel_s2    <= 1'b0;
            sel_arm   <= 2'b00;
            sel_done  <= 1'b0;
            chan_left <= 1'b0;
        end else begin
            sel_s1  <= chan_sel_pin;
            sel_s2  <= sel_s1;
            sel_arm <= {sel_arm[0], 1'b1};
            if (sel_arm[1] && !sel_done) begin
                sel_done  <= 1'b1;                                  // [RQ5]
                chan_left <= (sel_s2 == pdm_pkg::PDM_LEFT);         // [RQ6]
            end
        end
    end

    // run permission brought over from the reference domain
    always_ff @(posedge link.pdm_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
        end else begin
            run_s1 <= settled;
            run_s2 <= run_s1;
        end
    end

    // =====================================================================
    // sigma-delta modulator (link clock)
    // =====================================================================

    // offset added, then held inside full scale
    always_comb begin
        biased = ACC_W'(sample) + DC_OFS;                           // [RQ9]
        if (biased > FS_POS) begin
            clipped = FS_POS;                                       // [RQ10]
        end else if (biased < FS_NEG) begin
            clipped = FS_NEG;                                       // [RQ10]
        end else begin
            clipped = biased;
        end
    end

    // first-order loop: bit density follows the input level
    always_ff @(posedge link.pdm_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc     <= '0;
            mod_bit <= 1'b0;
        end else begin
            mod_bit <= !acc[ACC_W-1];                               // [RQ7]
            // with OFFSET_PCT zero, zero input swings acc between 0 and -fs: 1,0,1,0
            acc <= acc + clipped - (acc[ACC_W-1] ? FS_NEG : FS_POS); // [RQ8]
        end
    end

    // =====================================================================
    // half-slot drive timing (link clock, both edges)
    // =====================================================================

    // toggles on the rising edge mark each new period
    always_ff @(posedge link.pdm_clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_tog <= 1'b0;
        end else begin
            rise_tog <= !rise_tog;
        end
    end

    // falling edge closes the high half and loads the left bit
    always_ff @(negedge link.pdm_clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_tog <= 1'b0;
            left_bit <= 1'b0;
        end else begin
            fall_tog <= rise_tog;
            left_bit <= mod_bit;                                    // [RQ1]
        end
    end

    // high between a rising edge and the next falling edge
    assign high_half = rise_tog ^ fall_tog;

    // drive only our own half; settled also gates, since the clock
    // may stop with the link logic frozen mid-period
    assign link.mic_dat = chan_left ? left_bit : mod_bit;           // [RQ2]
    assign link.mic_oe  = settled & run_s2 & sel_done &
                          (high_half ^ chan_left); // [RQ3] [RQ4]

    // =====================================================================
    // clock-rate watch (reference clock)
    // =====================================================================

    // period toggle crosses through two flops before the edge detect
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= rise_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    assign clk_edge = tog_s2 ^ tog_s3;
    assign timeout  = (per_cnt >= SLEEP_LIM);

    // reference cycles since the last link rising edge, saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt <= '0;
        end else if (clk_edge) begin
            per_cnt <= '0;
        end else if (!timeout) begin
            per_cnt <= per_cnt + 1'b1;
        end
    end

    // low_power_listen_mode rate recognised from the measured period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_listen_mode <= 1'b0;
        end else if (timeout) begin
            low_power_listen_mode <= 1'b0;
        end else if (clk_edge) begin
            low_power_listen_mode <= (per_cnt + 1'b1 >= LISTEN_LO) &&
                                     (per_cnt + 1'b1 <= LISTEN_HI); // [RQ11]
        end
    end

    // =====================================================================
    // power state (reference clock)
    // =====================================================================

    // slow or absent clock sleeps; settling restarts on every wake
    always_comb begin
        next_state = state;
        case (state)
            pdm_pkg::PDM_SLEEP: begin
                if (clk_edge) begin
                    next_state = pdm_pkg::PDM_WAKE;
                end
            end
            pdm_pkg::PDM_WAKE: begin
                if (timeout) begin
                    next_state = pdm_pkg::PDM_SLEEP;                // [RQ12]
                end else if (wake_cnt == WAKE_LAST) begin
                    next_state = pdm_pkg::PDM_RUN; // [RQ13] [RQ14]
                end
            end
            pdm_pkg::PDM_RUN: begin
                if (timeout) begin
                    next_state = pdm_pkg::PDM_SLEEP;                // [RQ12]
                end
            end
            default: begin
                next_state = pdm_pkg::PDM_SLEEP;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pdm_pkg::PDM_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // settling time counted only while waking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= '0;
        end else if (state != pdm_pkg::PDM_WAKE) begin
            wake_cnt <= '0;
        end else if (wake_cnt != WAKE_LAST) begin
            wake_cnt <= wake_cnt + 1'b1;                            // [RQ13]
        end
    end

    // status flags follow the next state so they match it exactly
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            asleep  <= 1'b1;
            settled <= 1'b0;
        end else begin
            asleep  <= (next_state == pdm_pkg::PDM_SLEEP);          // [RQ12]
            settled <= (next_state == pdm_pkg::PDM_RUN);
        end
    end

endmodule : pdm_mic

`default_nettype wire

// ---- logic/pdm_pkg.sv ----
// shared constants and types for the pdm microphone link
`default_nettype none

package pdm_pkg;

    // =====================================================================
    // reference timebase
    // =====================================================================
    localparam int REF_HZ = 10_000_000;
    localparam int REF_NS = 1_000_000_000 / REF_HZ;

    // =====================================================================
    // clock-rate mode thresholds
    // =====================================================================
    localparam int LISTEN_HZ        = 768_000;
    localparam int LISTEN_PERIOD_NS = 1_000_000_000 / LISTEN_HZ;
    // nominal link period in reference cycles, rounded to nearest
    localparam int LISTEN_CYC       = (LISTEN_PERIOD_NS + REF_NS / 2) / REF_NS;
    localparam int LISTEN_TOL_CYC   = 1;
    localparam int SLEEP_HZ        = 200_000;
    localparam int SLEEP_PERIOD_NS = 1_000_000_000 / SLEEP_HZ;
    // longest period still awake, rounded down
    localparam int SLEEP_CYC       = SLEEP_PERIOD_NS / REF_NS;

    // =====================================================================
    // wake-up and start-up settling
    // =====================================================================
    localparam int WAKE_MS  = 6;
    // least time, rounded up
    localparam int WAKE_CYC = (WAKE_MS * 1_000_000 + REF_NS - 1) / REF_NS;

    // =====================================================================
    // modulator and host settings
    // =====================================================================
    localparam int SAMPLE_W   = 16;
    localparam int OFFSET_PCT = 3;
    localparam int CLK_DIV    = 13;
    localparam int CLK_HI     = 6;
    localparam int DEC_N      = 64;
    localparam int DEC_W      = 20;

    // power state of the microphone, gray along sleep -> wake -> run
    typedef enum logic [1:0] {
        PDM_SLEEP = 2'b00,
        PDM_WAKE  = 2'b01,
        PDM_RUN   = 2'b11
    } pdm_state_t;

    // channel-select strap level: low is right, high is left
    typedef enum logic {
        PDM_RIGHT = 1'b0,
        PDM_LEFT  = 1'b1
    } pdm_chan_t;

endpackage : pdm_pkg

`default_nettype wire

// ---- logic/pdm_if.sv ----
// link between the pdm microphone and the host codec
`default_nettype none

interface pdm_if;
    logic pdm_clk;    // bit clock, made by the host
    logic mic_dat;    // microphone data driver value
    logic mic_oe;     // microphone data driver enable, high drives
    logic data_line;  // resolved level of the shared data wire

    modport mic (
        input  pdm_clk,
        output mic_dat,
        output mic_oe
    );

    modport host (
        output pdm_clk,
        input  data_line
    );
endinterface : pdm_if

`default_nettype wire

// ---- logic/pdm_codec.sv ----
// host codec end: bit clock divider, channel sampling, decimation
`default_nettype none

module pdm_codec #(
    parameter int CLK_DIV  = pdm_pkg::CLK_DIV,
    parameter int CLK_HI   = pdm_pkg::CLK_HI,
    parameter int WAKE_CYC = pdm_pkg::WAKE_CYC,
    parameter int DEC_N    = pdm_pkg::DEC_N,
    parameter int DEC_W    = pdm_pkg::DEC_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    pdm_if.host                   link,
    input  wire logic             clk_run,
    output logic [DEC_W-1:0]      right_word,
    output logic                  right_valid,
    output logic [DEC_W-1:0]      left_word,
    output logic                  left_valid,
    output logic                  data_ok
);

    // =====================================================================
    // sizes and constants
    // =====================================================================
    localparam int PH_W = $clog2(CLK_DIV);
    localparam int WK_W = $clog2(WAKE_CYC + 1);
    localparam int DN_W = $clog2(DEC_N);
    localparam logic [PH_W-1:0] PH_LAST  = PH_W'(CLK_DIV - 1);
    localparam logic [PH_W-1:0] PH_HI    = PH_W'(CLK_HI);
    localparam logic [PH_W-1:0] PH_RSAMP = PH_W'(CLK_HI - 1);
    localparam logic [WK_W-1:0] WK_LAST  = WK_W'(WAKE_CYC);
    localparam logic [DN_W-1:0] DN_LAST  = DN_W'(DEC_N - 1);

    logic [PH_W-1:0]  phase;
    logic [PH_W-1:0]  next_phase;
    logic             clk_q;
    logic             dat_s1;
    logic             dat_s2;
    logic             samp_r;
    logic             samp_l;
    logic [WK_W-1:0]  ok_cnt;
    logic [DN_W-1:0]  cnt_r;
    logic [DN_W-1:0]  cnt_l;
    logic [DEC_W-1:0] acc_r;
    logic [DEC_W-1:0] acc_l;

    // one pdm bit into a two's-complement integrator
    function automatic logic [DEC_W-1:0] pdm_step(
        input logic [DEC_W-1:0] acc_in,
        input logic             bit_in
    );
        pdm_step = bit_in ? acc_in + 1'b1 : acc_in - 1'b1;
    endfunction : pdm_step

    // =====================================================================
    // bit clock divider
    // =====================================================================
    assign next_phase = (phase == PH_LAST) ? '0 : phase + 1'b1;

    // idle parks on the last phase so a restart opens with a rising edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_LAST;
            clk_q <= 1'b0;
        end else if (clk_run) begin
            phase <= next_phase;
            clk_q <= (next_phase < PH_HI);                          // [RQ15]
        end else begin
            phase <= PH_LAST;
            clk_q <= 1'b0;
        end
    end

    assign link.pdm_clk = clk_q;

    // =====================================================================
    // data sampling
    // =====================================================================

    // line is a pin: two flops before any use
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_s1 <= 1'b0;
            dat_s2 <= 1'b0;
        end else begin
            dat_s1 <= link.data_line;
            dat_s2 <= dat_s1;
        end
    end

    // each channel taken late in its own half only
    assign samp_r = clk_run && (phase == PH_RSAMP);                 // [RQ17]
    assign samp_l = clk_run && (phase == PH_LAST);                  // [RQ17]

    // start-up data discarded until settling time has passed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ok_cnt  <= '0;
            data_ok <= 1'b0;
        end else if (!clk_run) begin
            ok_cnt  <= '0;
            data_ok <= 1'b0;
        end else if (ok_cnt != WK_LAST) begin
            ok_cnt  <= ok_cnt + 1'b1;
        end else begin
            data_ok <= 1'b1;
        end
    end

    // =====================================================================
    // decimation, integrate and dump per channel
    // =====================================================================

    // right channel, rising-edge half
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r       <= '0;
            acc_r       <= '0;
            right_word  <= '0;
            right_valid <= 1'b0;
        end else begin
            right_valid <= 1'b0;
            if (!data_ok) begin
                cnt_r <= '0;
                acc_r <= '0;
            end else if (samp_r) begin
                cnt_r <= cnt_r + 1'b1;
                if (cnt_r == DN_LAST) begin
                    right_word  <= pdm_step(acc_r, dat_s2);         // [RQ16]
                    right_valid <= 1'b1;
                    acc_r       <= '0;
                end else begin
                    acc_r <= pdm_step(acc_r, dat_s2);
                end
            end
        end
    end

    // left channel, falling-edge half
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_l      <= '0;
            acc_l      <= '0;
            left_word  <= '0;
            left_valid <= 1'b0;
        end else begin
            left_valid <= 1'b0;
            if (!data_ok) begin
                cnt_l <= '0;
                acc_l <= '0;
            end else if (samp_l) begin
                cnt_l <= cnt_l + 1'b1;
                if (cnt_l == DN_LAST) begin
                    left_word  <= pdm_step(acc_l, dat_s2);          // [RQ16]
                    left_valid <= 1'b1;
                    acc_l      <= '0;
                end else begin
                    acc_l <= pdm_step(acc_l, dat_s2);
                end
            end
        end
    end

endmodule : pdm_codec

`default_nettype wire

// ---- test/pdm_link_properties.sv ----
// link assertions for the codec and right-channel mic pair
`default_nettype none

module pdm_link_properties #(
    parameter int WAKE_CYC = pdm_pkg::WAKE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pdm_clk,
    input wire logic mic_dat,
    input wire logic mic_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_q;     // clock level one cycle back
    int   idle_cnt;  // cycles since the bit clock last moved
    int   run_cnt;   // cycles since reset or since the last sleep
    // =================================================================
    // helper counters
    // =================================================================
    // track clock idling and time spent awake
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q    <= 1'b0;
            idle_cnt <= 0;
            run_cnt  <= 0;
        end else begin
            clk_q    <= pdm_clk;
            idle_cnt <= (pdm_clk != clk_q) ? 0 : idle_cnt + (idle_cnt < 999);
            run_cnt  <= (idle_cnt > 100) ? 0 : run_cnt + (run_cnt < WAKE_CYC);
        end
    end
    // =================================================================
    // properties
    // =================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_high_half; (mic_oe && pdm_clk) [*6]; endsequence
    sequence s_low_half; (!mic_oe) [*7]; endsequence
    property p_only_high; mic_oe |-> pdm_clk; endproperty
    property p_whole_half;
        $rose(pdm_clk) && mic_oe |-> s_high_half ##1 !mic_oe;
    endproperty
    property p_low_gap; $fell(mic_oe) |-> s_low_half; endproperty
    property p_stable; mic_oe && $past(mic_oe) |-> $stable(mic_dat);
    endproperty
    property p_clk_period;
        $rose(pdm_clk) |-> pdm_clk [*6] ##1 (!pdm_clk) [*7];
    endproperty
    property p_every_period;
        $rose(pdm_clk) && mic_oe |-> ##13 (mic_oe || !pdm_clk);
    endproperty
    property p_sleep_off; idle_cnt > 100 |-> !mic_oe; endproperty
    property p_wake_wait; mic_oe |-> run_cnt >= WAKE_CYC; endproperty
    a_only_high: assert property (p_only_high)
        else $error("mic drove outside its half");
    a_whole_half: assert property (p_whole_half)
        else $error("drive did not span the half");
    a_low_gap: assert property (p_low_gap)
        else $error("line not released for the other half");
    a_stable: assert property (p_stable)
        else $error("data moved while driven");
    a_clk_period: assert property (p_clk_period)
        else $error("bit clock period wrong");
    a_every_period: assert property (p_every_period)
        else $error("a period went without its bit");
    a_sleep_off: assert property (p_sleep_off)
        else $error("line driven with clock stopped");
    a_wake_wait: assert property (p_wake_wait)
        else $error("data driven before settle time");
endmodule : pdm_link_properties

`default_nettype wire

// ---- test/testbench.sv ----
// stereo bench: codec, right mic and left mic on one data line
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 200;
    localparam int DLY  = 5;
    localparam int DW   = pdm_pkg::DEC_W;
    logic                                ref_clk;
    logic                                rst_n;
    logic                                clk_run;
    logic                                sel_r;
    logic                                sel_l;
    logic signed [pdm_pkg::SAMPLE_W-1:0] smp_r;
    logic signed [pdm_pkg::SAMPLE_W-1:0] smp_l;
    logic                                line;
    logic [DW-1:0]                       right_word;
    logic [DW-1:0]                       left_word;
    logic                                right_valid;
    logic                                chan_r;
    logic                                chan_l;
    logic                                listen_r;
    logic                                asleep_r;
    logic                                settled_r;
    logic                                settled_l;
    int                                  failures = 0;
    int                                  checks = 0;

    pdm_if if_r ();
    pdm_if if_l ();
    pdm_codec #(.WAKE_CYC(WAKE)) pdm_codec_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .link(if_r.host), .clk_run(clk_run),
        .right_word(right_word), .right_valid(right_valid),
        .left_word(left_word), .left_valid(), .data_ok());
    pdm_mic #(.WAKE_CYC(WAKE), .OFFSET_PCT(0)) pdm_mic_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(if_r.mic),
        .chan_sel_pin(sel_r), .sample(smp_r), .chan_left(chan_r),
        .low_power_listen_mode(listen_r), .asleep(asleep_r),
        .settled(settled_r));
    pdm_mic #(.WAKE_CYC(WAKE)) pdm_mic_l_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .link(if_l.mic), .chan_sel_pin(sel_l),
        .sample(smp_l), .chan_left(chan_l), .low_power_listen_mode(),
        .asleep(), .settled(settled_l));
    pdm_link_properties #(.WAKE_CYC(WAKE)) pdm_link_properties_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .pdm_clk(if_r.pdm_clk),
        .mic_dat(if_r.mic_dat), .mic_oe(if_r.mic_oe));

    // =================================================================
    // shared wire: one clock, one keeper data line
    // =================================================================
    assign if_l.pdm_clk = if_r.pdm_clk;
    assign if_r.data_line = line;
    assign if_l.data_line = line;
    initial line = 1'b0;
    // line keeps its last level while nobody drives
    always @* begin
        if (if_r.mic_oe) line = if_r.mic_dat;
        else if (if_l.mic_oe) line = if_l.mic_dat;
    end
    // two drivers at once would fight on the wire
    always @(negedge ref_clk) begin
        if (if_r.mic_oe && if_l.mic_oe) check(DW'(1), DW'(0));
    end
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // =================================================================
    // tasks
    // =================================================================
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic in_rng(input logic [DW-1:0] w, input int lo,
                                    input int hi);
        return $signed(w) >= lo && $signed(w) <= hi;
    endfunction : in_rng

    // wait for n decimated words, then for the left word behind them
    task automatic take_words(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge ref_clk);
                #1 k++;
            end while (right_valid !== 1'b1 && k < 1000);
            if (k >= 1000) check(DW'(0), DW'(1));
        end
        repeat (8) @(posedge ref_clk) #DLY;
    endtask : take_words

    task automatic print_verdict();
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // =================================================================
    // tests
    // =================================================================
    initial begin
        rst_n = 1'b0;
        clk_run = 1'b0;
        sel_r = 1'b0;
        sel_l = 1'b1;
        smp_r = '0;
        smp_l = '0;
        repeat (6) @(posedge ref_clk);
        #DLY rst_n = 1'b1;
        @(posedge ref_clk);
        #DLY clk_run = 1'b1;
        repeat (WAKE / 2) @(posedge ref_clk);
        check(DW'(settled_r), DW'(0));
        take_words(3);
        check(DW'(settled_r && settled_l), DW'(1));
        check(DW'(chan_r), DW'(0));
        check(DW'(chan_l), DW'(1));
        check(DW'(listen_r), DW'(1));
        check(right_word, DW'(0));
        check(DW'(in_rng(left_word, 0, 4)), DW'(1));
        // strap moves in mid-run, then full scale both ways
        sel_r = 1'b1;
        for (int i = 0; i < 2; i++) begin
            smp_r = i ? 16'sh8001 : 16'sh7fff;
            smp_l = smp_r;
            take_words(2);
            check(DW'(in_rng(right_word, i ? -64 : 60, i ? -58 : 64)),
                  DW'(1));
            check(DW'(in_rng(left_word, i ? -64 : 60, i ? -58 : 64)),
                  DW'(1));
        end
        // stop the clock low, sleep, then wake again
        @(negedge if_r.pdm_clk);
        @(posedge ref_clk);
        #DLY clk_run = 1'b0;
        repeat (100) @(posedge ref_clk);
        check(DW'(asleep_r), DW'(1));
        check(DW'(if_r.mic_oe || if_l.mic_oe), DW'(0));
        #DLY clk_run = 1'b1;
        repeat (WAKE / 2) @(posedge ref_clk);
        check(DW'(settled_r), DW'(0));
        take_words(3);
        check(DW'(settled_r), DW'(1));
        check(DW'(chan_r), DW'(0));
        check(DW'(in_rng(right_word, -64, -58)), DW'(1));
        print_verdict();
    end

    // cut a hang short
    initial begin
        #(30_000 * 100);
        failures++;
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
